// file: hw/awt_fad_div.sv
// Conversion clock divider: one-cycle tick every 16 or 32 mclk.
// Assumes restart is asserted when a sequence begins.
`timescale 1ns/100ps
`default_nettype none
`include "awt_params.svh"

module awt_fad_div
  import awt_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Control
  input wire logic restart,
  input wire logic div16,
  // Conversion clock tick
  output logic tick
);

  logic [4:0] cnt;
  wire [4:0] last = div16 ? `AWT_DIV16_LAST : `AWT_DIV32_LAST;
  wire wrap = (cnt == last);

  // Count mclk cycles, tick on wrap
  always_ff @(posedge mclk)
  begin
    if (srst || restart)
    begin
      cnt <= 5'h00;
      tick <= 1'b0;
    end
    else
    begin
      cnt <= wrap ? 5'h00 : cnt + 5'h01;
      tick <= wrap;
    end
  end

endmodule : awt_fad_div
`default_nettype wire

// file: hw/awt_params.svh
// Constants for the wait-mode conversion timing controller.
// Assumes an 8-bit register port and a 10 MHz mclk.
`ifndef AWT_PARAMS_SVH
`define AWT_PARAMS_SVH

// Register offsets
`define AWT_ADDR_MODE0 2'h0
`define AWT_ADDR_MODE1 2'h1
`define AWT_ADDR_STATUS 2'h2

// Mode register 0 fields
`define AWT_M0_CLK_SEL_BIT0 0
`define AWT_M0_CLK_SEL_BIT1 1
`define AWT_M0_CLK_SEL_BIT2 2
`define AWT_M0_VOLT_BIT0 3
`define AWT_M0_VOLT_BIT1 4
`define AWT_M0_CMP_EN 5
`define AWT_M0_START 6

// Mode register 1 fields
`define AWT_M1_LOW_SPEED 0
`define AWT_M1_HW_TRIG 1
`define AWT_M1_SEQUENTIAL 2
`define AWT_M1_SCAN 3

// Reset values
`define AWT_MODE0_RST 8'h00
`define AWT_MODE1_RST 8'h00

// Voltage mode and clock select encodings
`define AWT_VOLT_LOW1 2'h2
`define AWT_SEL_DIV32 3'h0
`define AWT_SEL_DIV16 3'h1

// Conversion clock dividers, minus one for the counter
`define AWT_DIV32_LAST 5'h1F
`define AWT_DIV16_LAST 5'h0F

// Phase lengths in conversion-clock cycles
`define AWT_START_FAD 7'h01
`define AWT_STAB_FAD 7'h04
`define AWT_CONV_FAD 7'h50
`define AWT_IRQD_FAD 7'h04
`define AWT_SEQ_SHORTEN 7'h03

// Settling after stop before the mode bits may change
`define AWT_CLK_PERIOD_NS 100
`define AWT_STOP_SETTLE_NS 200
`define AWT_STOP_SETTLE_CYC ((`AWT_STOP_SETTLE_NS + `AWT_CLK_PERIOD_NS - 1) / `AWT_CLK_PERIOD_NS)

`endif

// file: hw/awt_pkg.sv
// Types for the wait-mode conversion timing controller.
// Assumes nothing beyond the params header.
package awt_pkg;

  // Sequencer phases
  typedef enum logic [2:0] {
    AWT_IDLE,
    AWT_START,
    AWT_STAB,
    AWT_CONV,
    AWT_IRQD
  } awt_state_t;

endpackage : awt_pkg

// file: hw/awt_wait_ctrl.sv
// Wait-mode conversion timing controller: mode registers, divider choice,
// start/stabilize/convert/interrupt-delay sequencing.
// Assumes a single-cycle register port and a one-cycle hardware trigger pulse.
`timescale 1ns/100ps
`default_nettype none
`include "awt_params.svh"

module awt_wait_ctrl
  import awt_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Hardware trigger
  input wire logic hw_trigger,
  // Converter control
  output logic supply_on,
  output logic sampling,
  output logic [1:0] scan_pos,
  output logic conv_end_irq
);

  awt_state_t state;
  awt_state_t next_state;
  logic [7:0] mode0;
  logic [7:0] mode1;
  logic [6:0] fad_cnt;
  logic first_conv;
  logic run_hw;
  logic [1:0] settle_cnt;
  logic restart;
  logic tick;

  // Register decode
  wire wr_mode0 = wr && (addr == `AWT_ADDR_MODE0);
  wire wr_mode1 = wr && (addr == `AWT_ADDR_MODE1);
  wire start_bit = mode0[`AWT_M0_START];
  wire cmp_en = mode0[`AWT_M0_CMP_EN];
  wire hw_mode = mode1[`AWT_M1_HW_TRIG];
  wire seq_mode = mode1[`AWT_M1_SEQUENTIAL];
  wire scan_mode = mode1[`AWT_M1_SCAN];
  wire [2:0] clk_sel = {mode0[`AWT_M0_CLK_SEL_BIT2], mode0[`AWT_M0_CLK_SEL_BIT1], mode0[`AWT_M0_CLK_SEL_BIT0]};
  wire [1:0] volt_mode = {mode0[`AWT_M0_VOLT_BIT1], mode0[`AWT_M0_VOLT_BIT0]};
  wire low_speed = mode1[`AWT_M1_LOW_SPEED];

  // Divider choice; other settings fall back to divide by 32
  wire div16 = !low_speed && (volt_mode == `AWT_VOLT_LOW1) && (clk_sel == `AWT_SEL_DIV16);

  // Start events
  wire sw_start = wr_mode0 && wdata[`AWT_M0_START] && !start_bit && !hw_mode;
  wire hw_start = hw_trigger && hw_mode && start_bit && cmp_en;
  wire begin_run = (state == AWT_IDLE) && (sw_start || hw_start);
  wire stopped = !start_bit || !cmp_en;
  wire busy = (state != AWT_IDLE);
  // Stop while running, unless the same write restarts it
  wire abort = busy && stopped && !(wr_mode0 && wdata[`AWT_M0_START] && wdata[`AWT_M0_CMP_EN]);

  // Phase length and end of phase
  wire [6:0] irqd_len = seq_mode ? (`AWT_IRQD_FAD - `AWT_SEQ_SHORTEN) : `AWT_IRQD_FAD;
  wire [6:0] phase_len = (state == AWT_START) ? `AWT_START_FAD :
                         (state == AWT_STAB) ? `AWT_STAB_FAD :
                         (state == AWT_CONV) ? `AWT_CONV_FAD : irqd_len;
  wire phase_done = tick && (fad_cnt == phase_len - 7'h01);

  // Repeat decision and the skip for hardware-triggered repeats
  wire more = seq_mode || (scan_mode && (scan_pos != 2'h3));
  wire skip_stab = run_hw && (seq_mode || scan_mode);

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    case (state)
      AWT_IDLE:
        if (sw_start)
          next_state = AWT_START;
        else if (hw_start)
          next_state = AWT_START;
      AWT_START:
        if (phase_done)
          next_state = AWT_STAB;
      AWT_STAB:
        if (phase_done)
          next_state = AWT_CONV;
      AWT_CONV:
        if (phase_done)
          next_state = AWT_IRQD;
      AWT_IRQD:
        if (phase_done)
        begin
          if (!more)
            next_state = AWT_IDLE;
          else if (skip_stab)
            next_state = AWT_CONV;
          else
            next_state = AWT_STAB;
        end
      default:
        next_state = AWT_IDLE;
    endcase
  end

  // Divider restarts at the start event so timing counts from it
  assign restart = begin_run;

  awt_fad_div u_div (
    .mclk(mclk),
    .srst(srst),
    .restart(restart),
    .div16(div16),
    .tick(tick)
  );

  // Mode registers; start bit cleared when a one-shot or scan run ends outside hardware-trigger mode
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      mode0 <= `AWT_MODE0_RST;
      mode1 <= `AWT_MODE1_RST;
    end
    else
    begin
      if (wr_mode0)
        mode0 <= wdata;
      else if (!hw_mode && (state == AWT_IRQD) && phase_done && !more)
        mode0[`AWT_M0_START] <= 1'b0;
      if (wr_mode1)
        mode1 <= wdata;
    end
  end

  // Sequencer state, abort on stop
  always_ff @(posedge mclk)
  begin
    if (srst)
      state <= AWT_IDLE;
    else if (abort)
      state <= AWT_IDLE;
    else
      state <= next_state;
  end

  // Conversion-clock cycle count inside a phase
  always_ff @(posedge mclk)
  begin
    if (srst || begin_run || phase_done)
      fad_cnt <= 7'h00;
    else if (tick)
      fad_cnt <= fad_cnt + 7'h01;
  end

  // Run bookkeeping: first conversion, trigger source, scan position
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      first_conv <= 1'b0;
      run_hw <= 1'b0;
      scan_pos <= 2'h0;
    end
    else if (begin_run)
    begin
      first_conv <= 1'b1;
      run_hw <= hw_start;
      scan_pos <= 2'h0;
    end
    else if ((state == AWT_IRQD) && phase_done)
    begin
      first_conv <= 1'b0;
      scan_pos <= scan_mode ? scan_pos + 2'h1 : 2'h0;
    end
  end

  // Settling count after a stop before mode bits are safe to change
  always_ff @(posedge mclk)
  begin
    if (srst)
      settle_cnt <= 2'h0;
    else if (!stopped || busy)
      settle_cnt <= 2'(`AWT_STOP_SETTLE_CYC);
    else if (settle_cnt != 2'h0)
      settle_cnt <= settle_cnt - 2'h1;
  end

  // Converter outputs and the end-of-conversion pulse
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      supply_on <= 1'b0;
      sampling <= 1'b0;
      conv_end_irq <= 1'b0;
    end
    else
    begin
      // An abort drops the supply and sampling together with the state
      supply_on <= !abort && ((next_state == AWT_STAB) || (next_state == AWT_CONV));
      sampling <= !abort && (next_state == AWT_CONV);
      conv_end_irq <= (state == AWT_IRQD) && phase_done;
    end
  end

  // Status word; config_safe tells software the mode bits may change
  wire config_safe = stopped && !busy && (settle_cnt == 2'h0);
  wire [7:0] status = {3'h0, first_conv, scan_pos, config_safe, busy};
  wire [7:0] rd_mux = (addr == `AWT_ADDR_MODE0) ? mode0 :
                      (addr == `AWT_ADDR_MODE1) ? mode1 :
                      (addr == `AWT_ADDR_STATUS) ? status : 8'h00;

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk)
  begin
    if (srst)
      rdata <= 8'h00;
    else
      rdata <= rd ? rd_mux : 8'h00;
  end

endmodule : awt_wait_ctrl
`default_nettype wire

// file: verification/awt_trig_src.sv
// Hardware trigger source standing in for an on-chip event.
// Assumes the bench asks for one trigger at a time.
`timescale 1ns/100ps
`default_nettype none
module awt_trig_src
(
  // Clock
  input wire logic mclk,
  // Request and trigger pulse
  input wire logic fire,
  output logic hw_trigger
);
  // One-cycle pulse at the edge after a request
  always_ff @(posedge mclk)
    hw_trigger <= fire & ~hw_trigger;
endmodule : awt_trig_src
`default_nettype wire

// file: verification/awt_wait_ctrl_bench.sv
// Bench for the wait-mode timing controller.
// Assumes the register port and trigger source model.
`timescale 1ns/100ps
`default_nettype none
module awt_wait_ctrl_bench;
  logic mclk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, fire = 1'b0;
  logic hw_trigger, supply_on, sampling, conv_end_irq;
  logic [1:0] addr = 2'h0, scan_pos;
  logic [7:0] wdata = 8'h00, rdata, d;
  int fails = 0, compares = 0;
  awt_wait_ctrl u_awt_wait_ctrl (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .hw_trigger(hw_trigger), .supply_on(supply_on), .sampling(sampling),
    .scan_pos(scan_pos), .conv_end_irq(conv_end_irq));
  awt_trig_src u_awt_trig_src (.mclk(mclk), .fire(fire), .hw_trigger(hw_trigger));
  // 100 ns clock
  initial
    forever #50 mclk = ~mclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [1:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [1:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rreg
  // Times one conversion of n mclk per fad from the start edge to its end request
  // sf is 1 when a start event opens it: start time plus one mclk of registered start
  task automatic conv(input int n, input int sf, input int st, input int dl);
    int sup = 0;
    int smp = 0;
    int gap = 0;
    int i;
    #1;
    for (i = 0; i < 3200; i++)
    begin
      sup += (supply_on === 1'b1);
      smp += (sampling === 1'b1);
      gap = (sampling === 1'b1) ? 0 : gap + 1;
      @(posedge mclk);
      #1;
      if (conv_end_irq === 1'b1)
        break;
    end
    chk(conv_end_irq, 1'b1);
    chk(sup, (st + 80) * n);
    chk(smp, 80 * n);
    chk(gap, dl * n);
    chk(i + 1, (sf + st + 80 + dl) * n + sf);
  endtask : conv
  task automatic end_sim();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // Watchdog: about 20000 mclk against some 12500 that the tests use
  initial
  begin
    #2000000;
    fails++;
    end_sim();
  end
  // Test sequence
  initial
  begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    rreg(2'h0);
    chk(d, 8'h00);
    rreg(2'h1);
    chk(d, 8'h00);
    wreg(2'h3, 8'hFF);
    rreg(2'h3);
    chk(d, 8'h00);
    wreg(2'h0, 8'h70);
    conv(32, 1, 4, 4);
    rreg(2'h0);
    chk(d, 8'h30);
    wreg(2'h0, 8'h10);
    repeat (2) @(posedge mclk);
    wreg(2'h0, 8'h11);
    wreg(2'h0, 8'h71);
    conv(16, 1, 4, 4);
    wreg(2'h0, 8'h11);
    repeat (2) @(posedge mclk);
    wreg(2'h1, 8'h06);
    wreg(2'h0, 8'h71);
    // Trigger pulse lands at the edge where the timing starts
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    @(posedge mclk);
    conv(16, 1, 4, 1);
    conv(16, 0, 0, 1);
    // Stop mid-run: not safe at once, safe after the settling time
    wreg(2'h0, 8'h11);
    rreg(2'h2);
    chk(d[1:0], 2'h0);
    rreg(2'h2);
    chk(d[1:0], 2'h2);
    // Hardware-triggered scan of four positions
    wreg(2'h1, 8'h0A);
    wreg(2'h0, 8'h71);
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    @(posedge mclk);
    conv(16, 1, 4, 4);
    chk(scan_pos, 2'h1);
    conv(16, 0, 0, 4);
    chk(scan_pos, 2'h2);
    conv(16, 0, 0, 4);
    chk(scan_pos, 2'h3);
    conv(16, 0, 0, 4);
    chk(scan_pos, 2'h0);
    end_sim();
  end
endmodule : awt_wait_ctrl_bench
`default_nettype wire

// file: verification/awt_wait_ctrl_sva.sv
// Checker for the wait-mode timing controller ports.
// Assumes one mclk domain with srst synchronous.
`timescale 1ns/100ps
`default_nettype none
module awt_wait_ctrl_sva
  import awt_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Converter control
  input wire logic supply_on,
  input wire logic sampling,
  input wire logic [1:0] scan_pos,
  input wire logic conv_end_irq
);
  logic [11:0] stab_cnt, conv_cnt, conv_len, gap_cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // Phase lengths seen at the ports
  always_ff @(posedge mclk)
  begin
    stab_cnt <= (srst || !supply_on || sampling) ? 12'h000 : stab_cnt + 12'h001;
    conv_cnt <= (srst || !sampling) ? 12'h000 : conv_cnt + 12'h001;
    conv_len <= srst ? 12'h000 : (sampling ? conv_cnt + 12'h001 : conv_len);
    gap_cnt <= (srst || sampling) ? 12'h000 : gap_cnt + 12'h001;
  end
  irq_one_cycle_a: assert property (conv_end_irq |=> !conv_end_irq) else $error("irq too long");
  conv_in_supply_a: assert property (sampling |-> supply_on) else $error("conv w/o supply");
  stab_len_a: assert property ($rose(sampling) |-> stab_cnt inside {12'h000, 12'h040, 12'h080})
    else $error("stab length");
  conv_len_a: assert property (conv_end_irq |-> conv_len == 12'h500 || conv_len == 12'hA00)
    else $error("conv length");
  irq_gap_a: assert property (conv_end_irq |-> gap_cnt inside {[12'h00E:12'h082]})
    else $error("irq delay");
  conv_then_delay_a: assert property ($fell(sampling) |-> !supply_on) else $error("supply held");
  scan_hold_a: assert property (sampling && $past(sampling) |-> $stable(scan_pos)) else $error("scan moved");
  reset_quiet_a: assert property ($fell(srst) |-> !supply_on && !sampling && !conv_end_irq && scan_pos == 2'h0)
    else $error("reset outputs");
endmodule : awt_wait_ctrl_sva
bind awt_wait_ctrl awt_wait_ctrl_sva u_awt_wait_ctrl_sva (.mclk(mclk), .srst(srst), .supply_on(supply_on),
  .sampling(sampling), .scan_pos(scan_pos), .conv_end_irq(conv_end_irq));
`default_nettype wire
